// ===== design/address_breakpoint_unit.sv
`timescale 1ns/1ps
module address_breakpoint_unit (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  input  wire logic [brk_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  input  wire logic [15:0]                cpu_addr,
  input  wire logic                       cpu_addr_valid,
  input  wire logic                       cpu_addr_is_pc,
  input  wire logic                       cpu_wait_mode,
  input  wire logic                       cpu_stop_mode,
  input  wire logic                       cpu_brk_ack,
  input  wire logic                       cpu_rti,
  input  wire logic                       test_voltage,
  output logic                            brk_req,
  output logic                            timer_stop,
  output logic                            watchdog_disable,
  output logic                            flag_clear_allow,
  output logic                            wait_exit_indicator,
  output logic                            irq
);

  // ----------------------------------------------------------------
  // Input grouping
  // ----------------------------------------------------------------
  brk_pkg::reg_req_t req;
  brk_pkg::cpu_bus_t cpu;
  brk_pkg::state_t   st;
  brk_pkg::state_t   next_st;
  logic              addr_match;
  logic              soft_break;

  assign req.addr      = reg_addr;
  assign req.wdata     = reg_wdata;
  assign req.wr        = reg_wr;
  assign req.rd        = reg_rd;
  assign cpu.addr      = cpu_addr;
  assign cpu.valid     = cpu_addr_valid;
  assign cpu.is_pc     = cpu_addr_is_pc;
  assign cpu.wait_mode = cpu_wait_mode;
  assign cpu.stop_mode = cpu_stop_mode;
  assign cpu.brk_ack   = cpu_brk_ack;
  assign cpu.return_from_interrupt       = cpu_rti;

  // ----------------------------------------------------------------
  // Address comparator
  // ----------------------------------------------------------------
  // Only opcode and operand fetches from the program counter qualify.
  assign addr_match = st.match_en
                    & cpu.valid & cpu.is_pc
                    & ~cpu.stop_mode
                    & (cpu.addr == {st.addr_hi, st.addr_lo});

  assign soft_break = req.wr && req.addr == brk_pkg::OFS_STAT_CTRL
                    && req.wdata[brk_pkg::BIT_BRK_ACT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tv_s1 = test_voltage;
    next_st.tv_s2 = st.tv_s1;
    next_st.rdata = brk_pkg::RST_BYTE;

    if (req.wr) begin
      if (req.addr == brk_pkg::OFS_STAT_CTRL) begin
        next_st.match_en = req.wdata[brk_pkg::BIT_MATCH_EN];
        next_st.brk_act  = req.wdata[brk_pkg::BIT_BRK_ACT];
      end else if (req.addr == brk_pkg::OFS_ADDR_HIGH) begin
        next_st.addr_hi = req.wdata;
      end else if (req.addr == brk_pkg::OFS_ADDR_LOW) begin
        next_st.addr_lo = req.wdata;
      end else if (req.addr == brk_pkg::OFS_WAIT_STAT) begin
        if (!req.wdata[brk_pkg::BIT_WAIT_FLAG]) begin
          next_st.wait_flag = 1'b0;
        end
      end else if (req.addr == brk_pkg::OFS_FLAG_CTRL) begin
        next_st.clr_en = req.wdata[brk_pkg::BIT_CLR_EN];
      end else if (req.addr == brk_pkg::OFS_EVT_MASK) begin
        next_st.mask = req.wdata[brk_pkg::EVT_N-1:0];
      end
    end

    if (req.rd) begin
      if (req.addr == brk_pkg::OFS_STAT_CTRL) begin
        next_st.rdata[brk_pkg::BIT_MATCH_EN] = st.match_en;
        next_st.rdata[brk_pkg::BIT_BRK_ACT]  = st.brk_act;
      end else if (req.addr == brk_pkg::OFS_ADDR_HIGH) begin
        next_st.rdata = st.addr_hi;
      end else if (req.addr == brk_pkg::OFS_ADDR_LOW) begin
        next_st.rdata = st.addr_lo;
      end else if (req.addr == brk_pkg::OFS_WAIT_STAT) begin
        next_st.rdata[brk_pkg::BIT_WAIT_FLAG] = st.wait_flag;
      end else if (req.addr == brk_pkg::OFS_FLAG_CTRL) begin
        next_st.rdata[brk_pkg::BIT_CLR_EN] = st.clr_en;
      end else if (req.addr == brk_pkg::OFS_EVT_STAT) begin
        next_st.rdata[brk_pkg::EVT_N-1:0] = st.evt;
        next_st.evt = brk_pkg::RST_EVT;
      end else if (req.addr == brk_pkg::OFS_EVT_MASK) begin
        next_st.rdata[brk_pkg::EVT_N-1:0] = st.mask;
      end
    end

    // Hardware sets win over software clears in the same cycle.
    if (addr_match) begin
      next_st.brk_act = 1'b1;
      next_st.evt[brk_pkg::EVT_MATCH] = 1'b1;
    end
    if (soft_break) begin
      next_st.evt[brk_pkg::EVT_SOFT] = 1'b1;
    end

    // Break state entered when the CPU takes the break, left on return.
    if (cpu.brk_ack) begin
      next_st.in_brk = 1'b1;
      if (cpu.wait_mode) begin
        next_st.wait_flag = 1'b1;
      end
    end else if (cpu.return_from_interrupt) begin
      next_st.in_brk = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Request stands from the match until the CPU enters the break.
  assign brk_req = st.brk_act & ~st.in_brk;
  assign timer_stop = st.in_brk;
  assign watchdog_disable = st.in_brk & st.tv_s2;
  assign flag_clear_allow = ~st.in_brk | st.clr_en;
  assign wait_exit_indicator = st.wait_flag;
  assign irq = |(st.evt & st.mask);
  assign reg_rdata = st.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_match_sets_active: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && addr_match |=> st.brk_act && (st.in_brk || brk_req))
    else $error("match did not raise break request");

  a_nonpc_no_match: assert property (
    @(posedge clk) disable iff (!rst_b)
    !cpu_addr_is_pc |-> !addr_match)
    else $error("non program address matched");

  a_soft_break: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && soft_break && !st.in_brk && !cpu_brk_ack
    |=> brk_req)
    else $error("software break gave no request");

  a_rti_ends_break: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && cpu_rti && !cpu_brk_ack |=> !timer_stop)
    else $error("return did not end break state");

  a_timer_held: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && cpu_brk_ack ##1 (!(clk_en && cpu_rti))[*3]
    |-> timer_stop)
    else $error("timers ran during break");

  a_watchdog_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    watchdog_disable |-> timer_stop && $past(test_voltage, 2))
    else $error("watchdog disabled without test voltage");

  a_stop_frozen: assert property (
    @(posedge clk) disable iff (!rst_b)
    cpu_stop_mode && !reg_wr |=> $stable(st.addr_hi)
      && $stable(st.addr_lo) && $stable(st.match_en))
    else $error("stop mode changed registers");

  a_enable_gates: assert property (
    @(posedge clk) disable iff (!rst_b)
    !st.match_en |-> !addr_match)
    else $error("match while disabled");

  a_addr_full: assert property (
    @(posedge clk) disable iff (!rst_b)
    addr_match |-> cpu_addr[15:8] == st.addr_hi
      && cpu_addr[7:0] == st.addr_lo)
    else $error("partial address compare");

  a_wait_flag: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && cpu_brk_ack && cpu_wait_mode |=> wait_exit_indicator)
    else $error("wait exit not flagged");

  a_flag_protect: assert property (
    @(posedge clk) disable iff (!rst_b)
    timer_stop && !st.clr_en |-> !flag_clear_allow)
    else $error("flags clearable in break");

  a_freeze_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    !clk_en |=> $stable(st))
    else $error("state moved while clock enable low");

  a_match_request: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && addr_match && !st.in_brk && !cpu_brk_ack |=> brk_req)
    else $error("match gave no break request");

  a_match_event: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && addr_match |=> st.evt[brk_pkg::EVT_MATCH])
    else $error("match event not recorded");

  a_soft_event: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && soft_break |=> st.evt[brk_pkg::EVT_SOFT])
    else $error("software break event not recorded");

  a_break_entry: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && cpu_brk_ack |=> timer_stop)
    else $error("timers not stopped on break entry");

  a_watchdog_on: assert property (
    @(posedge clk) disable iff (!rst_b)
    timer_stop && $past(test_voltage, 2) && $past(clk_en)
      && $past(clk_en, 2) && $past(rst_b, 2) |-> watchdog_disable)
    else $error("watchdog not disabled under test voltage");

  a_wait_compare: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && cpu_wait_mode && !cpu_stop_mode && st.match_en
      && cpu_addr_valid && cpu_addr_is_pc
      && cpu_addr == {st.addr_hi, st.addr_lo} |=> st.brk_act)
    else $error("no break while waiting");

  a_stop_quiet: assert property (
    @(posedge clk) disable iff (!rst_b)
    cpu_stop_mode |-> !addr_match)
    else $error("match in stop mode");

  a_enable_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == brk_pkg::OFS_STAT_CTRL
    |=> st.match_en == $past(reg_wdata[brk_pkg::BIT_MATCH_EN]))
    else $error("match enable write lost");

  a_ctrl_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_rd && reg_addr == brk_pkg::OFS_STAT_CTRL
    |=> reg_rdata[brk_pkg::BIT_BRK_ACT] == $past(st.brk_act)
      && reg_rdata[brk_pkg::BIT_MATCH_EN] == $past(st.match_en))
    else $error("control read back wrong");

  a_active_sticky: assert property (
    @(posedge clk) disable iff (!rst_b)
    st.brk_act
      && !(clk_en && reg_wr && reg_addr == brk_pkg::OFS_STAT_CTRL)
    |=> st.brk_act)
    else $error("break active lost without a write");

  a_active_clear: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == brk_pkg::OFS_STAT_CTRL
      && !reg_wdata[brk_pkg::BIT_BRK_ACT] && !addr_match
    |=> !st.brk_act)
    else $error("break active not cleared by write");

  a_high_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == brk_pkg::OFS_ADDR_HIGH
    |=> st.addr_hi == $past(reg_wdata))
    else $error("high address write lost");

  a_low_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == brk_pkg::OFS_ADDR_LOW
    |=> st.addr_lo == $past(reg_wdata))
    else $error("low address write lost");

  a_addr_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    !(clk_en && reg_wr) |=> $stable(st.addr_hi) && $stable(st.addr_lo))
    else $error("address changed without a write");

  a_high_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_rd && reg_addr == brk_pkg::OFS_ADDR_HIGH
    |=> reg_rdata == $past(st.addr_hi))
    else $error("high address read back wrong");

  a_wait_clear: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_wr && reg_addr == brk_pkg::OFS_WAIT_STAT
      && !reg_wdata[brk_pkg::BIT_WAIT_FLAG] && !cpu_brk_ack
    |=> !wait_exit_indicator)
    else $error("break wait flag not cleared");

  a_wait_sticky: assert property (
    @(posedge clk) disable iff (!rst_b)
    wait_exit_indicator
      && !(clk_en && reg_wr && reg_addr == brk_pkg::OFS_WAIT_STAT)
    |=> wait_exit_indicator)
    else $error("break wait flag lost");

  a_wait_no_set: assert property (
    @(posedge clk) disable iff (!rst_b)
    !wait_exit_indicator && !(clk_en && cpu_brk_ack && cpu_wait_mode)
    |=> !wait_exit_indicator)
    else $error("break wait flag set without a wait exit");

  a_flag_free: assert property (
    @(posedge clk) disable iff (!rst_b)
    !timer_stop || st.clr_en |-> flag_clear_allow)
    else $error("flag clearing blocked outside protection");

  a_event_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && reg_rd && reg_addr == brk_pkg::OFS_EVT_STAT
      && !addr_match && !soft_break |=> st.evt == brk_pkg::RST_EVT)
    else $error("event status not cleared by read");

  a_read_pulse: assert property (
    @(posedge clk) disable iff (!rst_b)
    clk_en && !reg_rd |=> reg_rdata == brk_pkg::RST_BYTE)
    else $error("read data stood too long");

endmodule

// ===== design/brk_pkg.sv
package brk_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 3;
  localparam logic [2:0]  OFS_STAT_CTRL   = 3'h0;
  localparam logic [2:0]  OFS_ADDR_HIGH   = 3'h1;
  localparam logic [2:0]  OFS_ADDR_LOW    = 3'h2;
  localparam logic [2:0]  OFS_WAIT_STAT   = 3'h3;
  localparam logic [2:0]  OFS_FLAG_CTRL   = 3'h4;
  localparam logic [2:0]  OFS_EVT_STAT    = 3'h5;
  localparam logic [2:0]  OFS_EVT_MASK    = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          BIT_MATCH_EN    = 7;
  localparam int          BIT_BRK_ACT     = 6;
  localparam int          BIT_WAIT_FLAG   = 1;
  localparam int          BIT_CLR_EN      = 7;
  localparam int          EVT_MATCH       = 0;
  localparam int          EVT_SOFT        = 1;
  localparam int          EVT_N           = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [1:0]  RST_EVT         = 2'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        valid;
    logic        is_pc;
    logic        wait_mode;
    logic        stop_mode;
    logic        brk_ack;
    logic        return_from_interrupt;
  } cpu_bus_t;

  typedef struct packed {
    logic             match_en;
    logic             brk_act;
    logic [7:0]       addr_hi;
    logic [7:0]       addr_lo;
    logic             wait_flag;
    logic             clr_en;
    logic             in_brk;
    logic             tv_s1;
    logic             tv_s2;
    logic [EVT_N-1:0] evt;
    logic [EVT_N-1:0] mask;
    logic [7:0]       rdata;
  } state_t;

endpackage

// ===== tb/address_breakpoint_unit_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module address_breakpoint_unit_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [15:0] cpu_addr = 16'h0000;
  logic        cpu_addr_valid = 1'b0;
  logic        cpu_addr_is_pc = 1'b0;
  logic        cpu_wait_mode = 1'b0;
  logic        cpu_stop_mode = 1'b0;
  logic        cpu_brk_ack;
  logic        cpu_rti;
  logic        test_voltage = 1'b0;
  logic        rti_go = 1'b0;
  logic [3:0]  ack_delay = 4'h3;
  logic        brk_req;
  logic        timer_stop;
  logic        watchdog_disable;
  logic        flag_clear_allow;
  logic        wait_exit_indicator;
  logic        irq;
  logic [7:0]  rdv;
  logic [15:0] miss [4] = '{16'h1235, 16'h1334, 16'h9234, 16'h0234};
  int          errors = 0;
  int          num_checks = 0;

  always #20 clk = ~clk;

  address_breakpoint_unit dut_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid), .cpu_addr_is_pc(cpu_addr_is_pc),
    .cpu_wait_mode(cpu_wait_mode), .cpu_stop_mode(cpu_stop_mode),
    .cpu_brk_ack(cpu_brk_ack), .cpu_rti(cpu_rti),
    .test_voltage(test_voltage), .brk_req(brk_req),
    .timer_stop(timer_stop), .watchdog_disable(watchdog_disable),
    .flag_clear_allow(flag_clear_allow),
    .wait_exit_indicator(wait_exit_indicator), .irq(irq));

  cpu_model cpu_u (.clk(clk), .rst_b(rst_b), .brk_req(brk_req),
    .ack_delay(ack_delay), .rti_go(rti_go), .cpu_brk_ack(cpu_brk_ack),
    .cpu_rti(cpu_rti));

  // ----------------------------------------------------------------
  // Access tasks.
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
    `CHK(rdv, e)
  endtask

  task automatic fetch(input logic [15:0] a, input logic pc);
    @(posedge clk);
    cpu_addr <= a;
    cpu_addr_valid <= 1'b1;
    cpu_addr_is_pc <= pc;
    @(posedge clk);
    cpu_addr_valid <= 1'b0;
    #1;
  endtask

  task automatic wait_ts(input logic v);
    for (int i = 0; i < 20 && timer_stop !== v; i++) @(posedge clk) #1;
    if (timer_stop !== v) begin
      errors++;
      give_verdict();
    end
  endtask

  task automatic do_rti();
    @(posedge clk) rti_go <= 1'b1;
    @(posedge clk) rti_go <= 1'b0;
    wait_ts(1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
    `CHK(flag_clear_allow, 1'b1)
    wr(3'h1, 8'h12);
    wr(3'h2, 8'h34);
    wr(3'h6, 8'h03);
    rd(3'h1, 8'h12);
    rd(3'h2, 8'h34);
    @(posedge clk) clk_en <= 1'b0;
    wr(3'h2, 8'hAA);
    @(posedge clk) clk_en <= 1'b1;
    rd(3'h2, 8'h34);
    fetch(16'h1234, 1'b1);
    `CHK(brk_req, 1'b0)
    wr(3'h0, 8'h80);
    rd(3'h0, 8'h80);
    for (int i = 0; i < 4; i++) begin
      fetch(miss[i], 1'b1);
      `CHK(brk_req, 1'b0)
    end
    fetch(16'h1234, 1'b0);
    `CHK(brk_req, 1'b0)
    @(posedge clk) cpu_stop_mode <= 1'b1;
    fetch(16'h1234, 1'b1);
    `CHK(brk_req, 1'b0)
    rd(3'h1, 8'h12);
    rd(3'h0, 8'h80);
    @(posedge clk) cpu_stop_mode <= 1'b0;
    fetch(16'h1234, 1'b1);
    `CHK(brk_req, 1'b1)
    `CHK(irq, 1'b1)
    rd(3'h0, 8'hC0);
    wait_ts(1'b1);
    `CHK(brk_req, 1'b0)
    `CHK(watchdog_disable, 1'b0)
    `CHK(flag_clear_allow, 1'b0)
    wr(3'h4, 8'h80);
    rd(3'h4, 8'h80);
    `CHK(flag_clear_allow, 1'b1)
    @(posedge clk) test_voltage <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK(watchdog_disable, 1'b1)
    wr(3'h0, 8'h80);
    rd(3'h0, 8'h80);
    do_rti();
    `CHK(watchdog_disable, 1'b0)
    `CHK(brk_req, 1'b0)
    rd(3'h5, 8'h01);
    `CHK(irq, 1'b0)
    @(posedge clk) cpu_wait_mode <= 1'b1;
    fetch(16'h1234, 1'b1);
    `CHK(brk_req, 1'b1)
    wait_ts(1'b1);
    `CHK(wait_exit_indicator, 1'b1)
    @(posedge clk) cpu_wait_mode <= 1'b0;
    rd(3'h3, 8'h02);
    wr(3'h0, 8'h00);
    do_rti();
    wr(3'h3, 8'h00);
    rd(3'h3, 8'h00);
    `CHK(wait_exit_indicator, 1'b0)
    wr(3'h0, 8'h40);
    `CHK(brk_req, 1'b1)
    wait_ts(1'b1);
    wr(3'h6, 8'h00);
    `CHK(irq, 1'b0)
    wr(3'h6, 8'h02);
    `CHK(irq, 1'b1)
    wr(3'h0, 8'h00);
    do_rti();
    rd(3'h5, 8'h03);
    `CHK(irq, 1'b0)
    give_verdict();
  end
endmodule

// ===== tb/cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// CPU side of the break handshake.
// ----------------------------------------------------------------
module cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       brk_req,
  input  wire logic [3:0] ack_delay,
  input  wire logic       rti_go,
  output logic            cpu_brk_ack,
  output logic            cpu_rti
);
  logic [3:0] cnt;
  logic       in_brk;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      in_brk <= 1'b0;
      cpu_brk_ack <= 1'b0;
      cpu_rti <= 1'b0;
    end else begin
      cpu_brk_ack <= 1'b0;
      cpu_rti <= 1'b0;
      if (brk_req && !in_brk && !cpu_brk_ack) begin
        cnt <= cnt + 4'h1;
        if (cnt >= ack_delay) begin
          cpu_brk_ack <= 1'b1;
          in_brk <= 1'b1;
          cnt <= 4'h0;
        end
      end
      if (rti_go && in_brk) begin
        cpu_rti <= 1'b1;
        in_brk <= 1'b0;
      end
    end
  end
endmodule
